// ===== core/pio_seq.v
// Purpose: Parallel word output/input sequencer, single and block
// Assumes: AHB-Lite slave, single word transfers, one clock
// Notes:   Machine cycle is three clock steps T1, T0, Tp
// Operation
// (RULE1) Output setup: parity check, fetch pending set
// (RULE2) Output active held during execution phase
// (RULE3) Fetch next word when no timeshare
// (RULE4) Slow ready accepted under fetch/timeshare gate
// (RULE5) Output valid while slow flag set
// (RULE6) Count block, terminate at all ones
// (RULE7) Parity check on each later block word
// (RULE8) Slow output second cycle re-arms fetch
// (RULE9) Leave execution when terminated and idle
// (RULE10) End signal in final phase, interrupts blocked
// (RULE11) Fast ready accepted, drives reply
// (RULE12) Fast flag clears next cycle's first step
// (RULE13) Input execution writes every memory cycle
// (RULE14) Slow input ready gated by store pending
// (RULE15) Input strobe; data captured on trailing edge
// (RULE16) Input address bumps except first word
// (RULE17) Mid-cycle input load sets store pending
// (RULE18) Store pending clears on clean store
// (RULE19) Final input write with done signal
// (RULE20) Fast input ready gated, captures lines
// (RULE21) Fast input bumps address after capture
// (RULE22) Far side picks speed by ready line
// (RULE23) Block end input sets terminate flag
// (RULE24) Slow transfer spans two cycles
`timescale 1ns/10ps
`default_nettype none
`include "pio_seq_defs.vh"

module pio_seq (
  // Clock and reset
  input  wire                   I_MCLK,
  input  wire                   I_RST_N,
  // AHB-Lite slave
  input  wire                   I_HSEL,
  input  wire [11:0]            I_HADDR,
  input  wire [1:0]             I_HTRANS,
  input  wire                   I_HWRITE,
  input  wire [2:0]             I_HSIZE,
  input  wire [31:0]            I_HWDATA,
  input  wire                   I_HREADY,
  output reg  [31:0]            O_HRDATA,
  output reg                    O_HREADYOUT,
  output reg                    O_HRESP,
  // External equipment
  input  wire                   I_READY_SLOW,
  input  wire                   I_READY_FAST,
  input  wire                   I_BLOCK_END_SIGNAL,
  input  wire [`PS_WORD_W-1:0]  I_INPUT_DATA_LINES,
  output reg                    O_OUTPUT_OP_ACTIVE,
  output reg                    O_OUTPUT_WORD_VALID,
  output reg  [`PS_WORD_W-1:0]  O_OUTPUT_DATA,
  output reg                    O_INPUT_STROBE,
  output reg                    O_INPUT_DONE,
  // Mainframe side
  input  wire                   I_TIMESHARE_CYCLE,
  output reg                    O_END_OF_INSTR,
  output reg                    O_INTR_BLOCK,
  output reg                    O_MEMORY_WRITE_SELECT
);

  // ==========================================================
  // Timing overview
  // Machine cycle is three clocks: T1, T0, Tp
  // Ready lines are looked at on T1 only
  // Slow word: accepted on T1 of cycle one
  //   slow_second_q marks cycle two
  //   word ends on Tp of cycle two
  // Fast word: accepted on T1, ends on its Tp
  //   fast flag drops at that same Tp edge
  // Output side:
  //   fetch loads the transfer register on T1
  //   address steps after each fetch
  //   fetch is re-armed as each word ends
  //   one extra fetch may follow the last word
  //   parity check is armed at setup and per word
  //   the check runs once the word is loaded
  // Input side:
  //   strobe falls on the capture edge
  //   slow capture on T0 of cycle two
  //   fast capture on T0 of its only cycle
  //   fast strobe raised straight from the accept
  //   address steps on the take: slow on T1 of cycle two, fast on T0; first word aside
  //   memory write on every Tp of execution outside timeshare
  //   slow capture marks the word for rewrite
  // Termination:
  //   single word, count wrap or block end
  //   exit only when no word is in flight
  //   input adds a final phase before the end
  // Hazards:
  //   capture and write share the transfer register
  //   a word caught mid-cycle is written twice
  //   timeshare holds off fetch and fast accept
  //   slow accept waits on it only while a fetch or store is pending
  // Bus side:
  //   writes land only while idle
  //   memory window writes use LEN as index
  //   reads answer with zero wait states
  //   status bit zero shows a running instruction
  // Limits:
  //   memory index is six bits wide
  //   count is twelve bits, wraps to all ones
  //   parity error is sticky until the next start

  // ==========================================================
  // Phases, one-hot
  localparam [4:0] PH_IDLE  = 5'h01;
  localparam [4:0] PH_SETUP = 5'h02;
  localparam [4:0] PH_EXEC  = 5'h04;
  localparam [4:0] PH_FIN   = 5'h08;
  localparam [4:0] PH_END   = 5'h10;

  reg  [4:0]            phase_q;
  reg  [1:0]            step_q;
  reg                   input_q, block_q, ts_sel_q;
  reg                   fetch_pending_q, slow_transfer_flag_q, slow_second_q;
  reg                   terminate_flag_q, fast_transfer_flag_q, store_pending_q;
  reg                   perr_q, done_q;
  reg  [`PS_WORD_W-1:0] len_q, xfer_q;
  reg  [`PS_ADDR_W-1:0] addr_q;
  reg                   parity_req_q;
  reg                   cpe_q;          // Parity check armed for next fetch
  // Bus phase registers
  reg                   bw_q, br_q;
  reg  [11:0]           ba_q;
  wire [`PS_WORD_W-1:0] mem_rdata;

  // ==========================================================
  // Timing helpers
  wire t1 = (step_q == `PS_STEP_T1);
  wire t0 = (step_q == `PS_STEP_T0);
  wire tp = (step_q == `PS_STEP_TP);
  wire ts = I_TIMESHARE_CYCLE | ts_sel_q;
  wire exec = phase_q[2];
  wire xfer_busy = slow_transfer_flag_q | fast_transfer_flag_q;
  wire word_done = (slow_transfer_flag_q & slow_second_q & tp) | (fast_transfer_flag_q & tp);
  wire [`PS_WORD_W-1:0] len_dec = len_q - 12'h001;
  wire bus_go = I_HSEL & I_HREADY & I_HTRANS[1];
  wire go_wr = bw_q & (ba_q == `PS_OFF_CTRL) & I_HWDATA[`PS_CTRL_GO] & phase_q[0];
  wire mem_we = exec & input_q & tp & ~ts;
  // Fast ready taken this step
  wire fast_acc = exec & t1 & I_READY_FAST & ~I_READY_SLOW & ~xfer_busy & ~terminate_flag_q & ~ts;
  // Input word taken: slow on second T1, fast on T0
  wire in_take = input_q & ((t1 & slow_transfer_flag_q & slow_second_q) | (t0 & fast_transfer_flag_q));

  // ==========================================================
  // Transfer word memory
  pio_word_mem u_mem (
    .clk   (I_MCLK),
    .we    (mem_we | (bw_q & (ba_q == `PS_OFF_MEMWIN) & phase_q[0])),
    .waddr (mem_we ? addr_q : len_q[`PS_ADDR_W-1:0]),
    .wdata (mem_we ? xfer_q : I_HWDATA[`PS_WORD_W-1:0]),
    .raddr (addr_q),
    .rdata (mem_rdata)
  );

  // ==========================================================
  // Step counter and phase sequencing
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      step_q  <= `PS_STEP_T1;
      phase_q <= PH_IDLE;
    end else begin
      step_q <= tp ? `PS_STEP_T1 : step_q + 2'h1;
      case (phase_q)
        PH_IDLE:  if (go_wr) phase_q <= PH_SETUP;
        PH_SETUP: if (tp) phase_q <= PH_EXEC;
        PH_EXEC:  if (tp && terminate_flag_q && !xfer_busy && !word_done) begin
                    phase_q <= input_q ? PH_FIN : PH_END; // RULE9
                  end
        PH_FIN:   if (tp) phase_q <= PH_END;
        PH_END:   if (tp) phase_q <= PH_IDLE;
        default:  phase_q <= PH_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Transfer flags, counters and transfer register
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fetch_pending_q      <= 1'b0;
      slow_transfer_flag_q <= 1'b0;
      slow_second_q        <= 1'b0;
      terminate_flag_q     <= 1'b0;
      fast_transfer_flag_q <= 1'b0;
      store_pending_q      <= 1'b0;
      parity_req_q         <= 1'b0;
      cpe_q                <= 1'b0;
      perr_q               <= 1'b0;
      len_q                <= `PS_LEN_RST;
      addr_q               <= `PS_ADDR_RST;
      xfer_q               <= 12'h000;
      input_q              <= 1'b0;
      block_q              <= 1'b0;
      ts_sel_q             <= 1'b0;
    end else begin
      parity_req_q <= 1'b0;
      // Register writes while idle
      if (bw_q && phase_q[0]) begin
        case (ba_q)
          `PS_OFF_CTRL: begin
            input_q  <= I_HWDATA[`PS_CTRL_INPUT];
            block_q  <= I_HWDATA[`PS_CTRL_BLOCK];
            ts_sel_q <= I_HWDATA[`PS_CTRL_TS];
          end
          `PS_OFF_LEN:  len_q  <= I_HWDATA[`PS_WORD_W-1:0];
          `PS_OFF_ADDR: addr_q <= I_HWDATA[`PS_ADDR_W-1:0];
          default: ;
        endcase
      end
      if (go_wr) perr_q <= 1'b0;
      // Setup: initial flag state
      if (phase_q[1] && tp) begin
        fetch_pending_q      <= 1'b1;              // RULE1
        terminate_flag_q     <= 1'b0;              // RULE1
        fast_transfer_flag_q <= 1'b0;              // RULE1
        store_pending_q      <= 1'b0;              // RULE1
        slow_transfer_flag_q <= 1'b0;              // RULE1
        slow_second_q        <= 1'b0;
        cpe_q                <= ~input_q;          // RULE1
      end
      if (exec) begin
        // Output fetch into transfer register
        if (!input_q && t1 && fetch_pending_q && !ts) begin
          xfer_q          <= mem_rdata;            // RULE3
          addr_q          <= addr_q + 6'h01;       // RULE3
          fetch_pending_q <= 1'b0;                 // RULE3
          if (cpe_q) begin
            parity_req_q <= 1'b1;                  // RULE1 RULE7
            cpe_q        <= 1'b0;
          end
        end
        // Slow ready acceptance
        if (t1 && I_READY_SLOW && !slow_transfer_flag_q && !fast_transfer_flag_q && !terminate_flag_q &&
            (input_q ? (!store_pending_q || !ts)          // RULE14
                     : (!fetch_pending_q || !ts))) begin  // RULE4
          slow_transfer_flag_q <= 1'b1;            // RULE22
          slow_second_q        <= 1'b0;
        end
        // Fast ready acceptance
        if (fast_acc) begin
          fast_transfer_flag_q <= 1'b1;            // RULE11 RULE20
        end
        if (slow_transfer_flag_q && tp && !slow_second_q) slow_second_q <= 1'b1; // RULE24
        // Input address bump before each later word
        if (in_take && !fetch_pending_q) begin
          addr_q <= addr_q + 6'h01;                // RULE16 RULE21
        end
        if (in_take) begin
          fetch_pending_q <= 1'b0;                 // RULE16
        end
        // Input capture on strobe trailing edge
        if (input_q && t0 && (fast_transfer_flag_q || (slow_transfer_flag_q && slow_second_q))) begin
          xfer_q <= I_INPUT_DATA_LINES;            // RULE15 RULE20
          if (slow_transfer_flag_q) store_pending_q <= 1'b1; // RULE17
        end else if (input_q && t0 && !ts && !slow_transfer_flag_q) begin
          store_pending_q <= 1'b0;                 // RULE18
        end
        // Word completion: count and terminate
        if (word_done) begin
          if (block_q) len_q <= len_dec;           // RULE6
          if (!block_q || len_dec == `PS_LEN_ALL1) terminate_flag_q <= 1'b1; // RULE6
          if (slow_transfer_flag_q) begin
            slow_transfer_flag_q <= 1'b0;          // RULE8
            if (!input_q) fetch_pending_q <= 1'b1; // RULE8
          end
          if (fast_transfer_flag_q && !input_q) fetch_pending_q <= 1'b1;
          if (!input_q && block_q && len_dec != `PS_LEN_ALL1 && !terminate_flag_q) begin
            cpe_q <= 1'b1;                         // RULE7
          end
        end
        // Fast flag lasts one machine cycle
        if (fast_transfer_flag_q && tp) fast_transfer_flag_q <= 1'b0; // RULE12
        if (I_BLOCK_END_SIGNAL) terminate_flag_q <= 1'b1; // RULE23
      end
      // Odd parity check on prepared word
      if (parity_req_q && ~^xfer_q) perr_q <= 1'b1;
    end
  end

  // ==========================================================
  // Handshake and phase outputs
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_OUTPUT_OP_ACTIVE    <= 1'b0;
      O_OUTPUT_WORD_VALID   <= 1'b0;
      O_OUTPUT_DATA         <= 12'h000;
      O_INPUT_STROBE        <= 1'b0;
      O_INPUT_DONE          <= 1'b0;
      O_END_OF_INSTR        <= 1'b0;
      O_INTR_BLOCK          <= 1'b0;
      O_MEMORY_WRITE_SELECT <= 1'b0;
      done_q                <= 1'b0;
    end else begin
      O_OUTPUT_OP_ACTIVE    <= exec & ~input_q;                                         // RULE2
      O_OUTPUT_WORD_VALID   <= exec & ~input_q & xfer_busy & ~word_done;                // RULE5 RULE11
      O_OUTPUT_DATA         <= xfer_q;                                                   // RULE5
      O_INPUT_STROBE        <= exec & input_q & ((xfer_busy & ~word_done & ~t0) | fast_acc); // RULE15
      O_INPUT_DONE          <= phase_q[3] & ~t1;                                         // RULE19
      O_END_OF_INSTR        <= phase_q[4];                                               // RULE10
      O_INTR_BLOCK          <= phase_q[4];                                               // RULE10
      O_MEMORY_WRITE_SELECT <= (exec | phase_q[3]) & input_q;                            // RULE13 RULE19
      if (go_wr) done_q <= 1'b0;
      else if (phase_q[4] && tp) done_q <= 1'b1;
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bw_q        <= 1'b0;
      br_q        <= 1'b0;
      ba_q        <= 12'h000;
      O_HRDATA    <= 32'h0000_0000;
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
    end else begin
      bw_q        <= bus_go & I_HWRITE;
      br_q        <= bus_go & ~I_HWRITE;
      ba_q        <= {I_HADDR[11:2], 2'b00};
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
      if (bus_go && !I_HWRITE) begin
        case ({I_HADDR[11:2], 2'b00})
          `PS_OFF_CTRL:   O_HRDATA <= {28'h0, ts_sel_q, block_q, input_q, 1'b0};
          `PS_OFF_LEN:    O_HRDATA <= {20'h0, len_q};
          `PS_OFF_ADDR:   O_HRDATA <= {26'h0, addr_q};
          `PS_OFF_STATUS: O_HRDATA <= {24'h0, done_q, perr_q, store_pending_q, fast_transfer_flag_q,
                                       terminate_flag_q, slow_transfer_flag_q, fetch_pending_q, ~phase_q[0]};
          `PS_OFF_XFER:   O_HRDATA <= {20'h0, xfer_q};
          default:        O_HRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // pio_seq
`default_nettype wire

// ===== core/pio_seq_defs.vh
// Purpose: Constants for the parallel word I/O sequencer
// Assumes: 32-bit AHB-Lite register bus, byte addresses
// Notes:   Offsets, fields, reset values and step counts
`ifndef PIO_SEQ_DEFS_VH
`define PIO_SEQ_DEFS_VH

// ==========================================================
// Register offsets (byte addresses)
`define PS_OFF_CTRL    12'h000
`define PS_OFF_LEN     12'h004
`define PS_OFF_ADDR    12'h008
`define PS_OFF_STATUS  12'h00C
`define PS_OFF_XFER    12'h010
`define PS_OFF_MEMWIN  12'h014

// ==========================================================
// Control fields
`define PS_CTRL_GO     0
`define PS_CTRL_INPUT  1
`define PS_CTRL_BLOCK  2
`define PS_CTRL_TS     3

// ==========================================================
// Status fields
`define PS_ST_BUSY     0
`define PS_ST_FETCH    1
`define PS_ST_SLOW     2
`define PS_ST_TERM     3
`define PS_ST_FAST     4
`define PS_ST_STORE    5
`define PS_ST_PERR     6
`define PS_ST_DONE     7

// ==========================================================
// Widths, reset values, timing
`define PS_WORD_W      12
`define PS_ADDR_W      6
`define PS_LEN_ALL1    12'hFFF
`define PS_LEN_RST     12'h000
`define PS_ADDR_RST    6'h00
`define PS_STEPS       2'h3
`define PS_STEP_T1     2'h0
`define PS_STEP_T0     2'h1
`define PS_STEP_TP     2'h2

`endif

// ===== core/pio_word_mem.v
// Purpose: Small word memory for transfer words
// Assumes: One write port, one registered read port
// Notes:   Read data comes from a flip-flop
`timescale 1ns/10ps
`default_nettype none
`include "pio_seq_defs.vh"

module pio_word_mem (
  // Clock
  input  wire                   clk,
  // Write port
  input  wire                   we,
  input  wire [`PS_ADDR_W-1:0]  waddr,
  input  wire [`PS_WORD_W-1:0]  wdata,
  // Read port
  input  wire [`PS_ADDR_W-1:0]  raddr,
  output reg  [`PS_WORD_W-1:0]  rdata
);

  reg [`PS_WORD_W-1:0] mem [0:(1<<`PS_ADDR_W)-1];

  // ==========================================================
  // Storage
  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule // pio_word_mem
`default_nettype wire

// ===== dv/pio_far_end.sv
// Purpose: External equipment model on the word connectors
// Assumes: Ready lines held as levels while enabled
// Notes:   Input word withdrawn after the strobe trailing edge
`timescale 1ns/10ps
`default_nettype none
module pio_far_end (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Bench controls
  input  wire logic        en,
  input  wire logic        fast,
  input  wire logic        be_en,
  input  wire logic        clr,
  // Sequencer side
  input  wire logic        valid,
  input  wire logic [11:0] odata,
  input  wire logic        strobe,
  output logic             rdy_slow,
  output logic             rdy_fast,
  output logic             blk_end,
  output logic [11:0]      idata
);
  logic [11:0] got_w [0:7];
  logic [11:0] in_w [0:1];
  int          n_got;
  int          n_in;
  logic        valid_q;
  logic        strobe_q;

  // Speed chosen by the ready line raised
  assign rdy_slow = en & ~fast;
  assign rdy_fast = en & fast;
  // Cut the block short once one word is seen
  assign blk_end = be_en & (n_got > 0);
  // Word held through strobe, inverted once used up
  assign idata = (n_in < 2) ? in_w[n_in[0]] : ~in_w[1];

  // Word capture and strobe counting
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      strobe_q <= 1'b0;
      n_got <= 0;
      n_in <= 0;
    end else begin
      valid_q <= valid;
      strobe_q <= strobe;
      if (clr) begin
        n_got <= 0;
        n_in <= 0;
      end else begin
        if (valid && !valid_q && n_got < 8) begin
          got_w[n_got[2:0]] <= odata;
          n_got <= n_got + 1;
        end
        if (strobe_q && !strobe) n_in <= n_in + 1;
      end
    end
  end
endmodule // pio_far_end
`default_nettype wire

// ===== dv/pio_seq_sva.sv
// Purpose: Port-level checks for the word I/O sequencer
// Assumes: One clock, reset active low and asynchronous
// Notes:   Attached to every pio_seq instance by bind
`timescale 1ns/10ps
`default_nettype none
module pio_seq_chk (
  // Clock and reset
  input wire logic        I_MCLK,
  input wire logic        I_RST_N,
  // Far side and bus
  input wire logic        I_READY_SLOW,
  input wire logic        I_READY_FAST,
  input wire logic        O_HREADYOUT,
  input wire logic        O_HRESP,
  // Link outputs
  input wire logic        O_OUTPUT_OP_ACTIVE,
  input wire logic        O_OUTPUT_WORD_VALID,
  input wire logic [11:0] O_OUTPUT_DATA,
  input wire logic        O_INPUT_STROBE,
  input wire logic        O_INPUT_DONE,
  input wire logic        O_END_OF_INSTR,
  input wire logic        O_INTR_BLOCK,
  input wire logic        O_MEMORY_WRITE_SELECT
);
  // ==========================================================
  // Common clocking
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  // ==========================================================
  // Link handshake
  valid_in_op_a: assert property (O_OUTPUT_WORD_VALID |-> O_OUTPUT_OP_ACTIVE)
    else $error("output valid outside output operation");
  valid_after_rdy_a: assert property ($rose(O_OUTPUT_WORD_VALID) |->
    ($past(I_READY_SLOW) || $past(I_READY_FAST) || $past(I_READY_SLOW, 2) || $past(I_READY_FAST, 2)))
    else $error("output valid without ready");
  strobe_after_rdy_a: assert property ($rose(O_INPUT_STROBE) |->
    ($past(I_READY_SLOW) || $past(I_READY_FAST) || $past(I_READY_SLOW, 2) || $past(I_READY_FAST, 2)))
    else $error("input strobe without ready");
  data_hold_a: assert property (O_OUTPUT_WORD_VALID && $past(O_OUTPUT_WORD_VALID) |-> $stable(O_OUTPUT_DATA))
    else $error("output data moved while valid");
  strobe_write_a: assert property (O_INPUT_STROBE |-> O_MEMORY_WRITE_SELECT && !O_OUTPUT_OP_ACTIVE)
    else $error("input strobe without write cycle");

  // ==========================================================
  // Final phases and bus response
  end_blk_intr_a: assert property (O_END_OF_INSTR |-> O_INTR_BLOCK)
    else $error("end without interrupt block");
  end_len_a: assert property ($rose(O_END_OF_INSTR) |-> O_END_OF_INSTR [*3] ##1 !O_END_OF_INSTR)
    else $error("end signal length wrong");
  done_len_a: assert property ($rose(O_INPUT_DONE) |-> ##1 O_INPUT_DONE ##1 !O_INPUT_DONE)
    else $error("input done length wrong");
  done_write_a: assert property (O_INPUT_DONE |-> O_MEMORY_WRITE_SELECT)
    else $error("input done without final write");
  done_then_end_a: assert property ($fell(O_INPUT_DONE) |-> ##[0:6] O_END_OF_INSTR)
    else $error("no end after input done");
  bus_okay_a: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus wait or error response");
endmodule // pio_seq_chk

bind pio_seq pio_seq_chk i_chk (
  .I_MCLK(I_MCLK), .I_RST_N(I_RST_N), .I_READY_SLOW(I_READY_SLOW), .I_READY_FAST(I_READY_FAST),
  .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP), .O_OUTPUT_OP_ACTIVE(O_OUTPUT_OP_ACTIVE),
  .O_OUTPUT_WORD_VALID(O_OUTPUT_WORD_VALID), .O_OUTPUT_DATA(O_OUTPUT_DATA), .O_INPUT_STROBE(O_INPUT_STROBE),
  .O_INPUT_DONE(O_INPUT_DONE), .O_END_OF_INSTR(O_END_OF_INSTR), .O_INTR_BLOCK(O_INTR_BLOCK),
  .O_MEMORY_WRITE_SELECT(O_MEMORY_WRITE_SELECT));
`default_nettype wire

// ===== dv/tb.sv
// Purpose: Self-checking bench for the word I/O sequencer
// Assumes: Registers reached by single AHB-Lite words
// Notes:   Memory contents checked by reading blocks back out
`timescale 1ns/10ps
`default_nettype none
`include "pio_seq_defs.vh"
module tb;
  // ==========================================================
  // Signals
  logic        clk, rst_n, hsel, hwrite, en, fast, be_en, clr;
  logic [11:0] haddr, odata, idata, m;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rd;
  logic        hready, hresp, oact, oval, istb, idone, eoi, iblk, mws, rs, rf, be;
  int          n_mismatch, checks;

  // Clock
  always #2 clk = ~clk;

  // ==========================================================
  // Design and far end
  pio_seq i_dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp), .I_READY_SLOW(rs), .I_READY_FAST(rf), .I_BLOCK_END_SIGNAL(be),
    .I_INPUT_DATA_LINES(idata), .O_OUTPUT_OP_ACTIVE(oact), .O_OUTPUT_WORD_VALID(oval), .O_OUTPUT_DATA(odata),
    .O_INPUT_STROBE(istb), .O_INPUT_DONE(idone), .I_TIMESHARE_CYCLE(1'b0), .O_END_OF_INSTR(eoi),
    .O_INTR_BLOCK(iblk), .O_MEMORY_WRITE_SELECT(mws));
  pio_far_end i_far (.clk(clk), .rst_n(rst_n), .en(en), .fast(fast), .be_en(be_en), .clr(clr), .valid(oval),
    .odata(odata), .strobe(istb), .rdy_slow(rs), .rdy_fast(rf), .blk_end(be), .idata(idata));

  // ==========================================================
  // Bus and check tasks
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic putw(input logic [11:0] idx, input logic [11:0] w);
    ahb(1'b1, `PS_OFF_LEN, {20'h0, idx});
    ahb(1'b1, `PS_OFF_MEMWIN, {20'h0, w});
  endtask
  // Start one instruction, poll status until idle
  task automatic run(input logic [11:0] a, input logic [11:0] len, input logic [3:0] ctrl);
    clr <= 1'b1;
    ahb(1'b1, `PS_OFF_ADDR, {20'h0, a});
    clr <= 1'b0;
    ahb(1'b1, `PS_OFF_LEN, {20'h0, len});
    en <= 1'b1;
    ahb(1'b1, `PS_OFF_CTRL, {28'h0, ctrl});
    repeat (2) @(posedge clk);
    do ahb(1'b0, `PS_OFF_STATUS, 32'h0); while (rd[0] !== 1'b0);
    en <= 1'b0;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial begin
    {clk, rst_n, hsel, hwrite, en, fast, be_en, clr, htrans, haddr, hwdata} = '0;
    n_mismatch = 0;
    checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(`PS_OFF_STATUS, 32'h0);
    rchk(`PS_OFF_LEN, 32'h0);
    rchk(12'h018, 32'h0);
    $display("test reset values done");
    putw(12'h004, 12'h007);
    putw(12'h005, 12'h003);
    putw(12'h00A, 12'h111);
    putw(12'h00B, 12'h0E0);
    putw(12'h00C, 12'hA8F);
    putw(12'h020, 12'h007);
    run(12'h004, 12'h000, 4'h1);
    chk({31'h0, rd[6]}, 32'h0);
    chk(i_far.n_got, 32'd1);
    chk({20'h0, i_far.got_w[0]}, 32'h007);
    rchk(`PS_OFF_ADDR, 32'h006);
    run(12'h005, 12'h000, 4'h1);
    chk({31'h0, rd[6]}, 32'h1);
    $display("test slow single output done");
    fast <= 1'b1;
    run(12'h00A, 12'h002, 4'h5);
    chk({31'h0, rd[6]}, 32'h0);
    chk(i_far.n_got, 32'd3);
    chk({20'h0, i_far.got_w[0]}, 32'h111);
    chk({20'h0, i_far.got_w[1]}, 32'h0E0);
    chk({20'h0, i_far.got_w[2]}, 32'hA8F);
    rchk(`PS_OFF_LEN, 32'hFFF);
    rchk(`PS_OFF_ADDR, 32'h00E);
    $display("test fast block output done");
    for (int s = 0; s < 2; s++) begin
      m = s ? 12'h010 : 12'h000;
      fast <= s[0];
      i_far.in_w[0] = 12'h3C1 ^ m;
      i_far.in_w[1] = 12'h5A4 ^ m;
      run(12'h014 + m, 12'h001, 4'h7);
      chk(i_far.n_in, 32'd2);
      rchk(`PS_OFF_XFER, {20'h0, 12'h5A4 ^ m});
      rchk(`PS_OFF_ADDR, {20'h0, 12'h015 + m});
      fast <= 1'b1;
      run(12'h014 + m, 12'h001, 4'h5);
      chk({20'h0, i_far.got_w[0]}, {20'h0, 12'h3C1 ^ m});
      chk({20'h0, i_far.got_w[1]}, {20'h0, 12'h5A4 ^ m});
      $display("test block input and read back done");
    end
    fast <= 1'b0;
    be_en <= 1'b1;
    run(12'h020, 12'h00A, 4'h5);
    chk(i_far.n_got, 32'd1);
    rchk(`PS_OFF_LEN, 32'h009);
    $display("test block end done");
    test_done();
  end

  // Watchdog on a hung wait
  initial begin
    #80000;
    n_mismatch++;
    $display("watchdog expired");
    test_done();
  end
endmodule // tb
`default_nettype wire
